// *** tas_defines.svh ***
`ifndef TAS_DEFINES_SVH
`define TAS_DEFINES_SVH

// register indices, byte address is index times four
`define TAS_IDX_FMT   10'h004
`define TAS_IDX_CMP   10'h005
`define TAS_IDX_CLK   10'h008
`define TAS_IDX_FLT   10'h009
`define TAS_IDX_STS   10'h00A

// reset values
`define TAS_FMT_RST   16'h4050
`define TAS_CMP_RST   16'h0000
`define TAS_CLK_RST   16'h0040
`define TAS_FLT_RST   16'h0000

// serial_format_control fields
`define TAS_LSRC      15
`define TAS_RSRC      14
`define TAS_TDM       13
`define TAS_SLOT      12
`define TAS_BINV      8
`define TAS_LINV      7
`define TAS_WL        6:5
`define TAS_FMTSEL    4:3

// frame formats and word lengths
`define TAS_FMT_RJ    2'h0
`define TAS_FMT_LJ    2'h1
`define TAS_FMT_I2S   2'h2
`define TAS_FMT_DSP   2'h3
`define TAS_WL_16     2'h0
`define TAS_WL_20     2'h1
`define TAS_WL_24     2'h2
`define TAS_WL_32     2'h3

// compand_control fields
`define TAS_COMP      2
`define TAS_LAW       1

// clock_output_control fields
`define TAS_MSTR      15
`define TAS_LDIR      11
`define TAS_DIV       10:0
`define TAS_DIV_MIN   11'h008

// pin_float_control field
`define TAS_TRIS      13

// converter sample width
`define TAS_REAL_BITS 13'sh0018

`endif

// *** tas_pkg.sv ***
package tas_pkg;

    typedef struct packed {
        logic [15:0] fmt;
        logic [15:0] cmp;
        logic [15:0] clk;
        logic [15:0] flt;
        logic [31:0] prdata;
        logic        pslverr;
        logic [2:0]  bs;
        logic [2:0]  ls;
        logic        bclk_f;
        logic        lrc_f;
        logic        eff_q;
        logic        bclk_g;
        logic [7:0]  gdiv;
        logic [10:0] lcnt;
        logic [10:0] pos;
        logic [10:0] hlen;
        logic        ll;
        logic        drv;
        logic [23:0] lh;
        logic [23:0] rh;
        logic [23:0] lw;
        logic [23:0] rw;
        logic        bclk_o;
        logic        lrc_o;
        logic        sd;
        logic        bclk_oe;
        logic        lrc_oe;
        logic        sd_oe;
    } tas_state_type;

endpackage

// *** tas_compand.sv ***
`timescale 1ns/100ps
module tas_compand (
    input  wire logic [23:0] sample,
    input  wire logic        comp,
    input  wire logic        law,
    output logic      [7:0]  code
);
    logic [13:0] mx;
    logic [12:0] am;
    logic [13:0] mb;
    logic [12:0] ab;
    logic [2:0]  me;
    logic [2:0]  ae;
    logic [12:0] mm;
    logic [12:0] amt;

    always_comb begin
        mx = sample[23] ? 14'(~sample[23:10] + 14'h0001) : sample[23:10];
        am = sample[23] ? 13'(~sample[23:11] + 13'h0001) : sample[23:11];
        // magnitude clamp and bias
        mb = (mx > 14'h1FDE) ? 14'h1FFF : 14'(mx + 14'h0021);
        ab = (am > 13'h0FFF) ? 13'h0FFF : am;
        me = 3'h0;
        ae = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (mb[i + 5]) begin
                me = 3'(i);
            end
            if (ab[i + 4]) begin
                ae = 3'(i);
            end
        end
        mm = 13'(mb >> (me + 3'h1));
        amt = (ae == 3'h0) ? 13'(ab >> 1) : 13'(ab >> ae);
        if (!comp) begin
            code = sample[23:16];
        end else if (law) begin
            code = {~sample[23], ae, amt[3:0]} ^ 8'h55;
        end else begin
            code = ~{sample[23], me, mm[3:0]};
        end
    end
endmodule

// *** tas_serial_out.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "tas_defines.svh"
module tas_serial_out #(
    parameter int BCLK_HALF = 4
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] sample_left,
    input  wire logic [23:0] sample_right,
    input  wire logic        sample_strobe,
    input  wire logic        bit_clock_in,
    output logic             bit_clock_out,
    output logic             bit_clock_oe,
    input  wire logic        frame_clock_in,
    output logic             frame_clock_out,
    output logic             frame_clock_oe,
    output logic             serial_data_out,
    output logic             serial_data_oe
);
    if (BCLK_HALF < 2 || BCLK_HALF > 255) begin : g_chk
        $error("BCLK_HALF must lie in 2..255");
    end

    tas_pkg::tas_state_type st;
    tas_pkg::tas_state_type n;

    logic [9:0]         idx;
    logic               mstr;
    logic               gen;
    logic               tdm;
    logic               dsp;
    logic               eight;
    logic               tris;
    logic               cv;
    logic               eff;
    logic               fall;
    logic               llg;
    logic               start;
    logic               left;
    logic               drive;
    logic               hole;
    logic [10:0]        div;
    logic [10:0]        lc;
    logic [5:0]         wid;
    logic signed [12:0] span;
    logic signed [12:0] base;
    logic signed [12:0] lead;
    logic signed [12:0] k;
    logic [4:0]         bi;
    logic [7:0]         lcode;
    logic [7:0]         rcode;

    tas_compand u_cl (
        .sample (st.lw),
        .comp   (st.cmp[`TAS_COMP]),
        .law    (st.cmp[`TAS_LAW]),
        .code   (lcode)
    );

    tas_compand u_cr (
        .sample (st.rw),
        .comp   (st.cmp[`TAS_COMP]),
        .law    (st.cmp[`TAS_LAW]),
        .code   (rcode)
    );

    always_comb begin
        n = st;
        idx = paddr[11:2];
        mstr = st.clk[`TAS_MSTR];
        gen = mstr | st.clk[`TAS_LDIR];
        tdm = st.fmt[`TAS_TDM];
        dsp = st.fmt[`TAS_FMTSEL] == `TAS_FMT_DSP;
        eight = st.cmp[`TAS_COMP] | st.cmp[`TAS_LAW];
        tris = st.flt[`TAS_TRIS];
        // frame level to left-half flag and back
        cv = (st.fmt[`TAS_FMTSEL] == `TAS_FMT_I2S) ^ (st.fmt[`TAS_LINV] & ~dsp);
        div = (st.clk[`TAS_DIV] < `TAS_DIV_MIN) ? `TAS_DIV_MIN : st.clk[`TAS_DIV];
        unique case (st.fmt[`TAS_WL])
            `TAS_WL_16: wid = 6'h10;
            `TAS_WL_20: wid = 6'h14;
            `TAS_WL_24: wid = 6'h18;
            `TAS_WL_32: wid = 6'h20;
        endcase
        if (eight) begin
            wid = 6'h08;
        end
        span = dsp ? 13'({wid, 1'b0}) : 13'(wid);
        base = (tdm && st.fmt[`TAS_SLOT]) ? span : 13'sh0000;

        // register bus
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            unique case (idx)
                `TAS_IDX_FMT: n.prdata = {16'h0000, st.fmt};
                `TAS_IDX_CMP: n.prdata = {16'h0000, st.cmp};
                `TAS_IDX_CLK: n.prdata = {16'h0000, st.clk};
                `TAS_IDX_FLT: n.prdata = {16'h0000, st.flt};
                `TAS_IDX_STS: n.prdata = {27'h0000000, st.drv, st.ll, st.sd_oe,
                                          st.lrc_oe, st.bclk_oe};
                default: begin
                    n.prdata = 32'h00000000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite) begin
            unique case (idx)
                `TAS_IDX_FMT: n.fmt = pwdata[15:0];
                `TAS_IDX_CMP: n.cmp = pwdata[15:0];
                `TAS_IDX_CLK: n.clk = pwdata[15:0];
                `TAS_IDX_FLT: n.flt = pwdata[15:0];
                default: n.fmt = st.fmt;
            endcase
        end

        // pin synchronisers
        n.bs = {st.bs[1:0], bit_clock_in};
        n.ls = {st.ls[1:0], frame_clock_in};
        if (st.bs[1] == st.bs[2]) begin
            n.bclk_f = st.bs[2];
        end
        if (st.ls[1] == st.ls[2]) begin
            n.lrc_f = st.ls[2];
        end
        if (sample_strobe) begin
            n.lh = sample_left;
            n.rh = sample_right;
        end

        // bit clock generator
        if (mstr) begin
            if (st.gdiv == 8'(BCLK_HALF - 1)) begin
                n.gdiv = 8'h00;
                n.bclk_g = ~st.bclk_g;
            end else begin
                n.gdiv = st.gdiv + 8'h01;
            end
        end else begin
            n.gdiv = 8'h00;
            n.bclk_g = 1'b0;
        end
        eff = mstr ? st.bclk_g : (st.bclk_f ^ st.fmt[`TAS_BINV]);
        n.eff_q = eff;
        fall = st.eff_q & ~eff;
        n.bclk_o = n.bclk_g ^ st.fmt[`TAS_BINV];

        // frame tracking and data launch on falling bit clock
        lc = (11'(st.lcnt + 11'h001) >= div) ? 11'h000 : 11'(st.lcnt + 11'h001);
        llg = dsp ? (lc == 11'h000) : (lc < {1'b0, div[10:1]});
        start = 1'b0;
        if (fall) begin
            if (gen) begin
                n.lcnt = lc;
                n.ll = llg;
                n.lrc_o = llg ^ cv;
            end else begin
                n.ll = st.lrc_f ^ cv;
            end
            start = dsp ? (n.ll & ~st.ll) : (n.ll != st.ll);
            if (start) begin
                n.hlen = st.pos;
                n.pos = 11'h001;
                if (n.ll) begin
                    n.lw = st.fmt[`TAS_LSRC] ? st.rh : st.lh;
                    n.rw = st.fmt[`TAS_RSRC] ? st.rh : st.lh;
                end
            end else if (st.pos != 11'h7FF) begin
                n.pos = st.pos + 11'h001;
            end
        end

        unique case (st.fmt[`TAS_FMTSEL])
            `TAS_FMT_RJ: lead = 13'(n.hlen) + 13'sh0001 - (tdm ? span <<< 1 : span);
            `TAS_FMT_LJ: lead = 13'sh0001;
            `TAS_FMT_I2S: lead = 13'sh0002;
            `TAS_FMT_DSP: lead = st.fmt[`TAS_LINV] ? 13'sh0001 : 13'sh0002;
        endcase
        k = 13'(n.pos) - lead - base;
        left = n.ll;
        if (dsp) begin
            left = k < 13'(wid);
            if (!left) begin
                k = k - 13'(wid);
            end
        end
        drive = k >= 13'sh0000 && k < 13'(wid) && k < `TAS_REAL_BITS;
        // word bits past the real sample are left floating
        hole = k >= `TAS_REAL_BITS && k < 13'(wid);
        bi = k[4:0];
        if (fall) begin
            n.drv = drive;
            if (!drive) begin
                n.sd = 1'b0;
            end else if (eight) begin
                n.sd = left ? lcode[3'(5'h07 - bi)] : rcode[3'(5'h07 - bi)];
            end else begin
                n.sd = left ? st.lw[5'h17 - bi] : st.rw[5'h17 - bi];
            end
        end

        // pin drivers
        n.bclk_oe = mstr & ~tris;
        n.lrc_oe = gen & ~tris;
        n.sd_oe = ~tris & (tdm ? n.drv : ~hole);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
            st.fmt <= `TAS_FMT_RST;
            st.cmp <= `TAS_CMP_RST;
            st.clk <= `TAS_CLK_RST;
            st.flt <= `TAS_FLT_RST;
        end else begin
            st <= n;
        end
    end

    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign pready = psel & penable;
    assign bit_clock_out = st.bclk_o;
    assign bit_clock_oe = st.bclk_oe;
    assign frame_clock_out = st.lrc_o;
    assign frame_clock_oe = st.lrc_oe;
    assign serial_data_out = st.sd;
    assign serial_data_oe = st.sd_oe;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_tris;
        st.flt[`TAS_TRIS] |=> !serial_data_oe && !bit_clock_oe && !frame_clock_oe;
    endproperty
    a_tris: assert property (p_tris) else $error("pin driven while floated");

    property p_slave;
        !st.clk[`TAS_MSTR] && !st.clk[`TAS_LDIR] |=> !bit_clock_oe && !frame_clock_oe;
    endproperty
    a_slave: assert property (p_slave) else $error("slave drives a clock pin");

    property p_force;
        st.clk[`TAS_LDIR] && !st.flt[`TAS_TRIS] |=> frame_clock_oe;
    endproperty
    a_force: assert property (p_force) else $error("frame clock not driven");

    property p_real;
        fall && hole |=> !serial_data_oe;
    endproperty
    a_real: assert property (p_real) else $error("bit beyond sample driven");

    property p_gap;
        fall && tdm && !drive |=> !serial_data_oe;
    endproperty
    a_gap: assert property (p_gap) else $error("data pin driven outside slot");

    property p_div;
        fall && gen && !(psel && penable && pwrite) |=> st.lcnt < div;
    endproperty
    a_div: assert property (p_div) else $error("frame counter past divider");

    property p_wl;
        !eight && st.fmt[`TAS_WL] == `TAS_WL_32 |-> wid == 6'h20;
    endproperty
    a_wl: assert property (p_wl) else $error("wrong word length");

    property p_mu;
        st.cmp[`TAS_COMP] && !st.cmp[`TAS_LAW] && st.rw == 24'h000000 |-> rcode == 8'hFF;
    endproperty
    a_mu: assert property (p_mu) else $error("mu-law zero code wrong");

    property p_wr;
        psel && penable && pwrite && idx == `TAS_IDX_FMT |=> st.fmt == $past(pwdata[15:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("format write lost");

    property p_rst;
        $rose(rst_b) |-> st.fmt == `TAS_FMT_RST && st.clk == `TAS_CLK_RST;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
endmodule

// *** tas_host_model.sv ***
`timescale 1ns/100ps
// far side: host mastering bit clock and frame clock of a slave port
module tas_host_model #(
    parameter int HALF_REF  = 8,
    parameter int HALF_BITS = 64
) (
    input  wire logic       ref_clk,
    input  wire logic       run,
    input  wire logic       inv,
    input  wire logic       dsp,
    input  wire logic       left_level,
    output logic            bit_clock,
    output logic            frame_clock,
    output logic            rise,
    output logic [7:0]      pos,
    output logic            right,
    output int              frames
);
    int         tick = 0;
    logic       bck  = 1'b0;
    logic [7:0] bitn = 8'h00;

    initial begin
        rise = 1'b0;
        pos = 8'h00;
        right = 1'b0;
        frames = 0;
    end

    // slow bit clock, room for both slots of the widest word
    always @(posedge ref_clk) begin
        rise <= 1'b0;
        if (run && tick == HALF_REF - 1) begin
            tick <= 0;
            bck <= ~bck;
            if (!bck) begin
                rise <= 1'b1;
                pos <= bitn + 8'h01;
            end else if (bitn == 8'(HALF_BITS - 1)) begin
                bitn <= 8'h00;
                right <= ~right;
                if (right)
                    frames <= frames + 1;
            end else begin
                bitn <= bitn + 8'h01;
            end
        end else if (run) begin
            tick <= tick + 1;
        end
    end

    // host never drives the shared data line
    assign bit_clock   = bck ^ inv;
    assign frame_clock = dsp ? (!right && bitn == 8'h00) : (right ^ left_level);
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
`include "tas_defines.svh"
module testbench;
    localparam logic [11:0] a_fmt = {`TAS_IDX_FMT, 2'b00};
    localparam logic [11:0] a_cmp = {`TAS_IDX_CMP, 2'b00};
    localparam logic [11:0] a_clk = {`TAS_IDX_CLK, 2'b00};
    localparam logic [11:0] a_flt = {`TAS_IDX_FLT, 2'b00};
    logic [15:0] fmts [11] = '{16'h4050, 16'h4008, 16'h4020, 16'h4058,
                               16'h81F8, 16'h7090, 16'h6058, 16'h4050,
                               16'h4050, 16'h4050, 16'h40D8};
    logic [15:0] cmps [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
                               16'h0, 16'h4, 16'h6, 16'h2, 16'h2};
    logic [15:0] codes [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
                                16'h0, 16'h80FF, 16'hAAD5, 16'h7F00, 16'h7F00};
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] sample_left = 24'h0;
    logic [23:0] sample_right = 24'h0;
    logic        sample_strobe = 1'b0;
    logic        bit_clock_out;
    logic        bit_clock_oe;
    logic        frame_clock_out;
    logic        frame_clock_oe;
    logic        serial_data_out;
    logic        serial_data_oe;
    logic        h_bck;
    logic        h_frm;
    logic        h_rise;
    logic [7:0]  h_pos;
    logic        h_right;
    int          h_frames;
    logic        h_run = 1'b0;
    logic        h_inv = 1'b0;
    logic        h_dsp = 1'b0;
    logic        h_lvl = 1'b0;
    logic        cd [0:129];
    logic        co [0:129];
    int          errors = 0;
    int          check_count = 0;

    always #5 ref_clk = ~ref_clk;

    tas_serial_out #(.BCLK_HALF(4)) i_tas_serial_out (
        .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sample_left, .sample_right, .sample_strobe,
        .bit_clock_in   (bit_clock_oe ? bit_clock_out : h_bck),
        .bit_clock_out, .bit_clock_oe,
        .frame_clock_in (frame_clock_oe ? frame_clock_out : h_frm),
        .frame_clock_out, .frame_clock_oe, .serial_data_out, .serial_data_oe
    );

    tas_host_model #(.HALF_REF(8), .HALF_BITS(64)) i_tas_host_model (
        .ref_clk, .run(h_run), .inv(h_inv), .dsp(h_dsp), .left_level(h_lvl),
        .bit_clock(h_bck), .frame_clock(h_frm), .rise(h_rise), .pos(h_pos),
        .right(h_right), .frames(h_frames)
    );

    // bit capture at each host rising edge, frame position 1..128
    always @(posedge ref_clk) begin
        if (h_rise) begin
            cd[int'(h_pos) + (h_right ? 64 : 0)] <= serial_data_out;
            co[int'(h_pos) + (h_right ? 64 : 0)] <= serial_data_oe;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
        check_count++;
        if (seen !== x) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            errors++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {16'h0, d}, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk("prdata", q, x);
        chk("pslverr", {31'h0, e}, {31'h0, xe});
    endtask

    task automatic pins(input logic [15:0] c, input logic [15:0] fl, input logic [2:0] x);
        wr(a_clk, c);
        wr(a_flt, fl);
        repeat (4) @(posedge ref_clk);
        chk("pin_oe", {29'h0, bit_clock_oe, frame_clock_oe, serial_data_oe}, {29'h0, x});
    endtask

    task automatic lvl(input logic v, inout int n);
        int t;
        t = 0;
        while (frame_clock_out !== v && t < 5000) begin
            @(posedge ref_clk);
            n++;
            t++;
        end
    endtask

    task automatic period(input logic [10:0] d);
        int n;
        wr(a_clk, {5'b10000, d});
        n = 0;
        lvl(1'b0, n);
        lvl(1'b1, n);
        n = 0;
        lvl(1'b0, n);
        lvl(1'b1, n);
        chk("frame_period", 32'(n), 32'(8 * int'(d)));
    endtask

    // master bit clock rises counted over 80 reference cycles
    task automatic bit_rate(input int x);
        logic b;
        int   r;
        b = bit_clock_out;
        r = 0;
        repeat (80) begin
            @(posedge ref_clk);
            if (bit_clock_out === 1'b1 && b === 1'b0)
                r++;
            b = bit_clock_out;
        end
        chk("bit_clock_rises", 32'(r), 32'(x));
    endtask

    task automatic word(input string nm, input int s, input int nb, input logic [31:0] x,
                        input bit fb, input bit fa);
        logic [31:0] g;
        logic [31:0] o;
        g = 32'h0;
        o = 32'h0;
        for (int i = 0; i < nb; i++) begin
            g = {g[30:0], cd[s + i]};
            o = {o[30:0], co[s + i]};
        end
        chk(nm, g, x);
        chk("drive", o, (32'h1 << nb) - 32'h1);
        if (fb)
            chk("float_before", {31'h0, co[s - 1]}, 32'h0);
        if (fa)
            chk("float_after", {31'h0, co[s + nb]}, 32'h0);
    endtask

    task automatic run_case(input int k);
        logic [15:0] f;
        logic [23:0] sl;
        logic [23:0] sr;
        int          w;
        int          nb;
        int          p;
        int          f0;
        int          t;
        bit          dsp;
        bit          eight;
        bit          tdm;
        f = fmts[k];
        eight = cmps[k][2] | cmps[k][1];
        dsp = f[4:3] == 2'h3;
        tdm = f[13];
        w = eight ? 8 : (f[6:5] == 2'h0 ? 16 : f[6:5] == 2'h1 ? 20 : f[6:5] == 2'h2 ? 24 : 32);
        nb = w > 24 ? 24 : w;
        sl = eight ? 24'h7FFFFF : 24'h9A5C3E;
        sr = eight ? 24'h000000 : 24'h61E6B5;
        p = f[4:3] == 2'h0 ? 65 - w : (f[4:3] == 2'h1 || (dsp && f[7])) ? 1 : 2;
        p = p + (f[12] ? (dsp ? 2 * w : w) : 0);
        h_inv <= f[8];
        h_dsp <= dsp;
        h_lvl <= (f[4:3] != 2'h2) ^ f[7];
        sample_left <= sl;
        sample_right <= sr;
        wr(a_fmt, f);
        wr(a_cmp, cmps[k]);
        @(posedge ref_clk);
        sample_strobe <= 1'b1;
        @(posedge ref_clk);
        sample_strobe <= 1'b0;
        f0 = h_frames;
        t = 0;
        while (h_frames < f0 + 2 && t < 9000) begin
            @(posedge ref_clk);
            t++;
        end
        if (t >= 9000)
            errors++;
        word("left_word", p, nb, eight ? 32'(codes[k][15:8]) : 32'((f[15] ? sr : sl) >> (24 - nb)),
             tdm, (w > nb) || (tdm && !dsp));
        word("right_word", dsp ? p + w : p + 64, nb,
             eight ? 32'(codes[k][7:0]) : 32'((f[14] ? sr : sl) >> (24 - nb)),
             1'b0, tdm || w > nb);
    endtask

    initial begin
        #(1_000_000);
        errors++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(a_fmt, 32'h00004050, 1'b0);
        rd(a_cmp, 32'h00000000, 1'b0);
        rd(a_clk, 32'h00000040, 1'b0);
        rd(a_flt, 32'h00000000, 1'b0);
        rd(12'h030, 32'h00000000, 1'b1);
        wr(a_cmp, 16'h0006);
        rd(a_cmp, 32'h00000006, 1'b0);
        wr(a_cmp, 16'h0000);
        pins(16'h0040, 16'h0000, 3'b001);
        pins(16'h0840, 16'h0000, 3'b011);
        pins(16'h8008, 16'h0000, 3'b111);
        period(11'h008);
        period(11'h00D);
        bit_rate(10);
        pins(16'h800D, 16'h2000, 3'b000);
        pins(16'h0040, 16'h0000, 3'b001);
        h_run <= 1'b1;
        for (int k = 0; k < 11; k++)
            run_case(k);
        summarize();
    end
endmodule
